// File: src/plc_sysop_regs.svh
// Constants for the system operation executor: selectors, reset values, timing
`ifndef PLC_SYSOP_REGS_SVH
`define PLC_SYSOP_REGS_SVH

// Accumulator selector values of the register-indirect load and store
`define IR_SEL_ACC1        8'h00
`define IR_SEL_ACC2        8'h02
// Operand codes of the second-bank load and store
`define BANK_SEL_ACC1      8'h01
`define BANK_SEL_ACC2      8'h02
// System data word that holds the scan monitoring time
`define SYS_WORD_SCAN_TIME 8'h60
// Reset values
`define ACCUM_RESET        16'h0000
`define PROG_POS_RESET     16'h0000
// Program position step of an ordinary statement
`define STMT_STEP          16'h0001
// Scan monitoring unit in milliseconds and the clock period in nanoseconds
`define SCAN_UNIT_MS       10
`define CLK_PERIOD_NS      25

`endif

// File: src/plc_sysop_pkg.sv
// Types shared by the system operation executor
package plc_sysop_pkg;

    // Operation codes presented on the instruction port
    typedef enum logic [3:0] {
        OP_NOP        = 4'h0,
        OP_LOAD_CONST = 4'h1,
        OP_IR_LOAD    = 4'h2,
        OP_IR_STORE   = 4'h3,
        OP_SB_LOAD    = 4'h4,
        OP_SB_STORE   = 4'h5,
        OP_BLOCK_COPY = 4'h6,
        OP_SYS_WRITE  = 4'h7,
        OP_REL_JUMP   = 4'h8,
        OP_ADD_BYTE   = 4'h9,
        OP_ADD_WORD   = 4'ha,
        OP_INDEXED    = 4'hb,
        OP_SWAP       = 4'hc,
        OP_STOP       = 4'hd
    } op_t;

    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_RD_HI = 7'h02,
        S_RD_LO = 7'h04,
        S_WR_HI = 7'h08,
        S_WR_LO = 7'h10,
        S_CP_RD = 7'h20,
        S_CP_WR = 7'h40
    } seq_state_t;

endpackage

// File: src/sys_data_ram.sv
// System data area: 256 words with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none

module sys_data_ram #(
    parameter int unsigned DEPTH = 256,
    parameter int unsigned AW    = 8,
    parameter int unsigned DW    = 16
) (
    input  wire logic          ref_clk,
    input  wire logic          ce,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    logic [DW-1:0] mem [DEPTH];  // Storage, no reset: contents set by software

    // Write port
    always_ff @(posedge ref_clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data come out of a register, one cycle after the address
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // sys_data_ram

`default_nettype wire

// File: src/scan_watchdog.sv
// Scan cycle monitor counting in 10 ms units against a programmed limit
`timescale 1ns/1ps
`default_nettype none

module scan_watchdog #(
    parameter int unsigned UNIT_CYCLES = 400000
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        run,
    input  wire logic        scan_restart,
    input  wire logic [15:0] limit,
    output logic             expire
);

    logic [31:0] unit_cnt;   // Cycles inside the current unit
    logic [15:0] units;      // Whole units elapsed in this scan

    // Counts units while running; a zero limit disables monitoring
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            unit_cnt <= 32'h0;
            units    <= 16'h0;
            expire   <= 1'b0;
        end else if (ce) begin
            expire <= 1'b0;
            if (!run || scan_restart || limit == 16'h0) begin
                unit_cnt <= 32'h0;
                units    <= 16'h0;
            end else if (unit_cnt == UNIT_CYCLES - 1) begin
                unit_cnt <= 32'h0;
                // Unit boundary: compare with this unit already counted
                if (units + 16'h1 >= limit) begin
                    units  <= 16'h0;
                    expire <= 1'b1;
                end else begin
                    units <= units + 16'h1;
                end
            end else begin
                unit_cnt <= unit_cnt + 32'h1;
            end
        end
    end

endmodule // scan_watchdog

`default_nettype wire

// File: src/plc_system_op_executor.sv
// Executor for privileged system operations on two 16-bit accumulators
`timescale 1ns/1ps
`default_nettype none
`include "plc_sysop_regs.svh"

// Contract
// (RULE1) Indirect load reads word at first-accumulator address
// (RULE2) Indirect store writes selected accumulator to memory
// (RULE3) Second-bank load fetches word from second bank
// (RULE4) Second-bank store writes accumulator into second bank
// (RULE5) Accumulators are 16 bits, transfers whole words
// (RULE6) Byte N is upper half, N+1 lower
// (RULE7) Indirect transfers ignore logic result, address accumulator one
// (RULE8) Loading accumulator one pushes old value down
// (RULE9) Block copy count from parameter, up to 255
// (RULE10) Copy source top in two, destination in one
// (RULE11) System write stores accumulator one to word
// (RULE12) System word 96 holds scan time in 10ms
// (RULE13) Memory changing operations are never access checked
// (RULE14) Relative jump adds signed statement displacement
// (RULE15) Add-immediate adds signed byte or word constant
// (RULE16) Add-immediate keeps logic result and condition codes
// (RULE17) Add overflow truncates, accumulator two untouched
// (RULE18) Indexed processing aims next statement at parameter; code takes the low byte of accumulator one instead
// (RULE19) Swap exchanges accumulators, flags untouched
// (RULE20) Immediate stop enters stop state at once
// (RULE21) Stop left only by selector or start
// (RULE22) Copy walks bytes downward until count zero
module plc_system_op_executor
    import plc_sysop_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = `SCAN_UNIT_MS * 1000000 / `CLK_PERIOD_NS
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        op_valid,
    input  wire logic [3:0]  op_code,
    input  wire logic [15:0] op_param,
    output logic             op_ready,
    output logic             op_done,
    output logic             mem_req,
    output logic             mem_we,
    output logic             mem_bank,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        scan_restart,
    input  wire logic        selector_start,
    input  wire logic        pg_start,
    input  wire logic [7:0]  sys_rd_addr,
    output logic [15:0]      sys_rd_data,
    output logic [15:0]      accum1,
    output logic [15:0]      accum2,
    output logic [15:0]      prog_pos,
    output logic             index_valid,
    output logic [7:0]       index_pos,
    output logic             cpu_stop,
    output logic             scan_timeout
);

    // Selector decode shared by loads and stores: {valid, picks accum2}
    function automatic logic [1:0] decode_sel(input op_t op, input logic [7:0] p);
        logic ir;
        ir = (op == OP_IR_LOAD || op == OP_IR_STORE);
        if (p == (ir ? `IR_SEL_ACC1 : `BANK_SEL_ACC1)) return 2'b10;
        if (p == (ir ? `IR_SEL_ACC2 : `BANK_SEL_ACC2)) return 2'b11;
        return 2'b00;
    endfunction

    // Byte constant widened to a word with its sign
    function automatic logic [15:0] sext8(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction

    op_t         op_in;        // Decoded incoming operation
    seq_state_t  state;        // Sequencer state
    logic        take;         // Operation accepted this cycle
    logic        to_acc2;      // Load target is the second accumulator
    logic [7:0]  rd_hi;        // Upper byte captured during a word read
    logic [7:0]  wr_lo;        // Lower byte waiting for the second write
    logic [7:0]  cp_count;     // Bytes left in a block copy
    logic [15:0] cp_src;       // Current source byte address
    logic [15:0] cp_dst;       // Current destination byte address
    logic [1:0]  sel;          // Selector decode of the incoming parameter
    logic [15:0] store_word;   // Accumulator picked by a store
    logic        ram_we;       // System data write strobe
    logic [7:0]  ram_addr;     // System data word number
    logic [15:0] ram_wdata;    // System data word value
    logic [15:0] scan_limit;   // Copy of word 96 for the monitor
    logic        wd_expire;    // Scan time ran out

    assign op_in      = op_t'(op_code);
    assign take       = op_valid && op_ready && !cpu_stop;
    assign sel        = decode_sel(op_in, op_param[7:0]);
    assign store_word = sel[0] ? accum2 : accum1;

    // Sequencer, memory port and accumulators
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state     <= S_IDLE;
            op_done   <= 1'b0;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_bank  <= 1'b0;
            mem_addr  <= 16'h0000;
            mem_wdata <= 8'h00;
            accum1    <= `ACCUM_RESET;
            accum2    <= `ACCUM_RESET;
            to_acc2   <= 1'b0;
            rd_hi     <= 8'h00;
            wr_lo     <= 8'h00;
            cp_count  <= 8'h00;
            cp_src    <= 16'h0000;
            cp_dst    <= 16'h0000;
        end else if (ce) begin
            op_done <= 1'b0;
            case (state)
                S_IDLE: begin
                    // Logic result plays no part in any of these
                    if (take) begin
                        case (op_in)
                            OP_LOAD_CONST: begin
                                accum2  <= accum1;   // RULE8
                                accum1  <= op_param;
                                op_done <= 1'b1;
                            end
                            OP_IR_LOAD, OP_SB_LOAD: begin
                                if (sel[1]) begin
                                    // Address always from accumulator one
                                    mem_req  <= 1'b1;     // RULE7
                                    mem_we   <= 1'b0;
                                    mem_bank <= (op_in == OP_SB_LOAD);  // RULE3
                                    mem_addr <= accum1;   // RULE1
                                    to_acc2  <= sel[0];
                                    state    <= S_RD_HI;
                                end else begin
                                    // Unknown selector completes with no transfer
                                    op_done <= 1'b1;
                                end
                            end
                            OP_IR_STORE, OP_SB_STORE: begin
                                if (sel[1]) begin
                                    // Upper half goes to byte N first
                                    mem_req   <= 1'b1;    // RULE7
                                    mem_we    <= 1'b1;
                                    mem_bank  <= (op_in == OP_SB_STORE);  // RULE4
                                    mem_addr  <= accum1;  // RULE2
                                    mem_wdata <= store_word[15:8];  // RULE6
                                    wr_lo     <= store_word[7:0];
                                    state     <= S_WR_HI;
                                end else begin
                                    op_done <= 1'b1;
                                end
                            end
                            OP_BLOCK_COPY: begin
                                // Highest addresses: source in two, destination in one
                                cp_count <= op_param[7:0];  // RULE9
                                cp_src   <= accum2;         // RULE10
                                cp_dst   <= accum1;         // RULE10
                                if (op_param[7:0] == 8'h00) begin
                                    op_done <= 1'b1;
                                end else begin
                                    mem_req  <= 1'b1;
                                    mem_we   <= 1'b0;
                                    mem_bank <= 1'b0;
                                    mem_addr <= accum2;
                                    state    <= S_CP_RD;
                                end
                            end
                            OP_ADD_BYTE: begin
                                // Carry beyond 16 bits is dropped, accumulator two kept
                                accum1  <= accum1 + sext8(op_param[7:0]);  // RULE15 RULE17
                                op_done <= 1'b1;   // RULE16
                            end
                            OP_ADD_WORD: begin
                                accum1  <= accum1 + op_param;  // RULE15 RULE17
                                op_done <= 1'b1;   // RULE16
                            end
                            OP_SWAP: begin
                                accum1  <= accum2;  // RULE19
                                accum2  <= accum1;  // RULE19
                                op_done <= 1'b1;
                            end
                            default: begin
                                // Ops handled by their own processes finish here
                                op_done <= 1'b1;
                            end
                        endcase
                    end
                end
                S_RD_HI: begin
                    if (mem_ack) begin
                        rd_hi    <= mem_rdata;           // RULE6
                        mem_addr <= mem_addr + 16'h0001;
                        state    <= S_RD_LO;
                    end
                end
                S_RD_LO: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        op_done <= 1'b1;
                        state   <= S_IDLE;
                        // Whole word lands in the chosen accumulator
                        if (to_acc2) begin
                            accum2 <= {rd_hi, mem_rdata};  // RULE5 RULE6
                        end else begin
                            accum2 <= accum1;              // RULE8
                            accum1 <= {rd_hi, mem_rdata};  // RULE5 RULE6
                        end
                    end
                end
                S_WR_HI: begin
                    if (mem_ack) begin
                        mem_addr  <= mem_addr + 16'h0001;
                        mem_wdata <= wr_lo;                // RULE6
                        state     <= S_WR_LO;
                    end
                end
                S_WR_LO: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we  <= 1'b0;
                        op_done <= 1'b1;
                        state   <= S_IDLE;
                    end
                end
                S_CP_RD: begin
                    // Byte read from source turns into a write at destination
                    if (mem_ack) begin
                        mem_we    <= 1'b1;
                        mem_addr  <= cp_dst;
                        mem_wdata <= mem_rdata;   // RULE10
                        state     <= S_CP_WR;
                    end
                end
                S_CP_WR: begin
                    if (mem_ack) begin
                        // Step both pointers down, count toward zero
                        cp_count <= cp_count - 8'h01;      // RULE22
                        cp_src   <= cp_src - 16'h0001;     // RULE22
                        cp_dst   <= cp_dst - 16'h0001;     // RULE22
                        mem_we   <= 1'b0;
                        if (cp_count == 8'h01) begin
                            mem_req <= 1'b0;
                            op_done <= 1'b1;
                            state   <= S_IDLE;
                        end else begin
                            // Addresses wrap freely; nothing is range checked
                            mem_addr <= cp_src - 16'h0001;  // RULE13
                            state    <= S_CP_RD;
                        end
                    end
                end
                default: begin
                    mem_req <= 1'b0;
                    mem_we  <= 1'b0;
                    state   <= S_IDLE;
                end
            endcase
        end
    end

    // Ready only while idle and running; drops the edge after a take
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            op_ready <= 1'b0;
        end else if (ce) begin
            op_ready <= !take && !cpu_stop && (state == S_IDLE);
        end
    end

    // System data write path, with word 96 mirrored for the monitor
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ram_we     <= 1'b0;
            ram_addr   <= 8'h00;
            ram_wdata  <= 16'h0000;
            scan_limit <= 16'h0000;
        end else if (ce) begin
            ram_we <= 1'b0;
            if (take && op_in == OP_SYS_WRITE) begin
                ram_we    <= 1'b1;             // RULE11 RULE13
                ram_addr  <= op_param[7:0];    // RULE11
                ram_wdata <= accum1;           // RULE11
                if (op_param[7:0] == `SYS_WORD_SCAN_TIME) begin
                    scan_limit <= accum1;      // RULE12
                end
            end
        end
    end

    // Program position: plain statements step by one, jumps by displacement
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prog_pos <= `PROG_POS_RESET;
        end else if (ce && take) begin
            // Signed displacement for jumps, no correction applied
            prog_pos <= prog_pos + ((op_in == OP_REL_JUMP) ? op_param : `STMT_STEP);  // RULE14
        end
    end

    // Index for the statement that follows an indexed-processing op
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            index_valid <= 1'b0;
            index_pos   <= 8'h00;
        end else if (ce && take) begin
            // Consumed by exactly one following statement
            index_valid <= (op_in == OP_INDEXED);  // RULE18
            if (op_in == OP_INDEXED) begin
                index_pos <= accum1[7:0];          // RULE18
            end
        end
    end

    // Stop state: entry wins over a simultaneous start request
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cpu_stop     <= 1'b0;
            scan_timeout <= 1'b0;
        end else if (ce) begin
            if ((take && op_in == OP_STOP) || wd_expire) begin
                cpu_stop <= 1'b1;                 // RULE20
            end else if (selector_start || pg_start) begin
                cpu_stop <= 1'b0;                 // RULE21
            end
            if (wd_expire) begin
                scan_timeout <= 1'b1;
            end else if (cpu_stop && (selector_start || pg_start)) begin
                scan_timeout <= 1'b0;
            end
        end
    end

    // System data area storage
    sys_data_ram #(.DEPTH (256), .AW (8), .DW (16)) u_ram (
        .ref_clk (ref_clk),
        .ce      (ce),
        .wr_en   (ram_we),
        .wr_addr (ram_addr),
        .wr_data (ram_wdata),
        .rd_addr (sys_rd_addr),
        .rd_data (sys_rd_data)
    );

    // Scan time monitor driven by word 96
    scan_watchdog #(.UNIT_CYCLES (UNIT_CYCLES)) u_wd (
        .ref_clk      (ref_clk),
        .rstn         (rstn),
        .ce           (ce),
        .run          (!cpu_stop),
        .scan_restart (scan_restart),
        .limit        (scan_limit),
        .expire       (wd_expire)
    );

endmodule // plc_system_op_executor

`default_nettype wire

// File: testbench/plc_sysop_assertions.sv
// Checker for the system operation executor
`timescale 1ns/1ps
`default_nettype none
module plc_sysop_assertions
    import plc_sysop_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        ce,
    input wire logic        op_valid,
    input wire logic [3:0]  op_code,
    input wire logic [15:0] op_param,
    input wire logic        op_ready,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic        selector_start,
    input wire logic        pg_start,
    input wire logic [15:0] accum1,
    input wire logic [15:0] accum2,
    input wire logic [15:0] prog_pos,
    input wire logic        cpu_stop
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Operation accepted at this edge
    wire take = ce && op_valid && op_ready && !cpu_stop;
    AST_SWAP: assert property (take && op_code == OP_SWAP |=>
        accum1 == $past(accum2) && accum2 == $past(accum1)) else $error("swap wrong");
    AST_ADD: assert property (take && op_code == OP_ADD_WORD |=>
        accum1 == 16'($past(accum1) + $past(op_param)) && $stable(accum2)) else $error("add wrong");
    AST_JUMP: assert property (take && op_code == OP_REL_JUMP |=>
        prog_pos == 16'($past(prog_pos) + $past(op_param))) else $error("jump wrong");
    AST_STOP: assert property (take && op_code == OP_STOP |=> cpu_stop) else $error("no stop");
    AST_HOLD: assert property (cpu_stop && !selector_start && !pg_start |=> cpu_stop)
        else $error("stop left");
    AST_IR_ADDR: assert property (take && op_code == OP_IR_LOAD && op_param[7:0] inside {8'h00, 8'h02} |=>
        mem_req && !mem_we && mem_addr == $past(accum1)) else $error("bad address");
    AST_MEM_HOLD: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("request moved");
    AST_PUSH: assert property (take && op_code == OP_LOAD_CONST |=>
        accum1 == $past(op_param) && accum2 == $past(accum1)) else $error("push wrong");
    cover property (take && op_code == OP_BLOCK_COPY);
    cover property (take && op_code == OP_SB_STORE);
    cover property (cpu_stop && pg_start);
endmodule // plc_sysop_assertions
bind plc_system_op_executor plc_sysop_assertions chk (.*);
`default_nettype wire

// File: testbench/mem_model.sv
// Byte memory model of program memory and second bank
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input  wire logic        ref_clk,
    input  wire logic [3:0]  lat,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic        mem_bank,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic             mem_ack,
    output logic [7:0]       mem_rdata
);
    logic [7:0] mem [int]; // Keyed by bank and address
    logic [3:0] cnt = 4'h0; // Wait cycles spent
    initial mem_ack = 1'b0;
    initial mem_rdata = 8'h5a;
    // Answer after lat cycles; data toggles outside the ack so stale bytes never pass
    always @(posedge ref_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (cnt >= lat) begin
                cnt <= 4'h0;
                mem_ack <= 1'b1;
                if (mem_we)
                    mem[{mem_bank, mem_addr}] = mem_wdata;
                else
                    mem_rdata <= mem[{mem_bank, mem_addr}];
            end else
                cnt <= cnt + 4'h1;
        end
    end
endmodule // mem_model
`default_nettype wire

// File: testbench/tb_top.sv
// Testbench for the system operation executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import plc_sysop_pkg::*;
    logic ref_clk = 0, rstn = 0, ce = 1, op_valid = 0, scan_restart = 0, selector_start = 0, pg_start = 0;
    logic [3:0] op_code = 4'h0, lat = 4'h0;
    logic [15:0] op_param = 16'h0, exp_pos = 16'h0;
    logic [7:0] sys_rd_addr = 8'h0;
    logic op_ready, op_done, mem_req, mem_we, mem_bank, mem_ack, index_valid, cpu_stop, scan_timeout;
    logic [7:0] mem_wdata, mem_rdata, index_pos;
    logic [15:0] mem_addr, sys_rd_data, accum1, accum2, prog_pos;
    int fail_count = 0, comparisons = 0, cycles = 0;
    plc_system_op_executor #(.UNIT_CYCLES(10)) uut (.*);
    mem_model mem (.*);
    initial forever #12.5 ref_clk = ~ref_clk;
    // Cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out;
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One operation: wait for ready, offer one cycle, wait for done
    task automatic op(input op_t c, input logic [15:0] p);
        int n;
        n = 0;
        while (op_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        op_valid = 1'b1;
        op_code = c;
        op_param = p;
        scan_restart = 1'b1;
        @(negedge ref_clk);
        op_valid = 1'b0;
        scan_restart = 1'b0;
        exp_pos = exp_pos + ((c == OP_REL_JUMP) ? p : 16'h0001);
        n = 0;
        while (op_done !== 1'b1 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        chk({15'h0, op_done}, 16'h0001);
    endtask
    task automatic t_transfer;
        mem.mem[17'h11231] = 8'h45;
        mem.mem[17'h11232] = 8'h67;
        mem.mem[17'h01231] = 8'haa;
        mem.mem[17'h01232] = 8'hbb;
        lat = 4'h3; // Slow memory first
        op(OP_LOAD_CONST, 16'h1231);
        op(OP_IR_LOAD, 16'h0002);
        chk(accum2, 16'haabb);
        op(OP_SB_LOAD, 16'h0002);
        chk(accum2, 16'h4567);
        chk(accum1, 16'h1231);
        op(OP_IR_LOAD, 16'h0000);
        chk(accum1, 16'haabb);
        chk(accum2, 16'h1231);
        lat = 4'h0;
        op(OP_LOAD_CONST, 16'h4466);
        op(OP_LOAD_CONST, 16'h2000);
        op(OP_SB_STORE, 16'h0002);
        chk({mem.mem[17'h12000], mem.mem[17'h12001]}, 16'h4466);
        op(OP_IR_STORE, 16'h0000);
        chk({mem.mem[17'h02000], mem.mem[17'h02001]}, 16'h2000);
    endtask
    task automatic t_copy;
        mem.mem[17'h00101] = 8'h22;
        mem.mem[17'h00102] = 8'h33;
        mem.mem[17'h00201] = 8'hee;
        op(OP_LOAD_CONST, 16'h0102);
        op(OP_LOAD_CONST, 16'h0203);
        op(OP_BLOCK_COPY, 16'h0002);
        chk({mem.mem[17'h00203], mem.mem[17'h00202]}, 16'h3322);
        chk({8'h0, mem.mem[17'h00201]}, 16'h00ee);
    endtask
    task automatic t_arith;
        op(OP_LOAD_CONST, 16'h7777);
        op(OP_LOAD_CONST, 16'h1020);
        op(OP_ADD_BYTE, 16'h00df);
        chk(accum1, 16'h0fff);
        op(OP_ADD_WORD, 16'hf100);
        chk(accum1, 16'h00ff);
        chk(accum2, 16'h7777);
        op(OP_SWAP, 16'h0000);
        chk(accum1, 16'h7777);
        op(OP_LOAD_CONST, 16'h0002);
        op(OP_INDEXED, 16'h0000);
        chk({7'h0, index_valid, index_pos}, 16'h0102);
        op(OP_REL_JUMP, 16'hfffe);
        chk(prog_pos, exp_pos);
    endtask
    task automatic t_stop;
        op(OP_STOP, 16'h0000);
        chk({15'h0, cpu_stop}, 16'h0001);
        op_valid = 1'b1; // Refused while stopped
        op_code = OP_LOAD_CONST;
        repeat (4) @(negedge ref_clk);
        op_valid = 1'b0;
        chk(accum1, 16'h0002);
        selector_start = 1'b1;
        @(negedge ref_clk);
        selector_start = 1'b0;
        @(negedge ref_clk);
        chk({15'h0, cpu_stop}, 16'h0000);
        op(OP_LOAD_CONST, 16'h0005);
        op(OP_SYS_WRITE, 16'h0060);
        sys_rd_addr = 8'h60;
        repeat (40) @(negedge ref_clk);
        chk(sys_rd_data, 16'h0005);
        chk({15'h0, scan_timeout}, 16'h0000);
        repeat (30) @(negedge ref_clk);
        chk({14'h0, scan_timeout, cpu_stop}, 16'h0003);
        pg_start = 1'b1;
        @(negedge ref_clk);
        pg_start = 1'b0;
        chk({14'h0, scan_timeout, cpu_stop}, 16'h0000);
    endtask
    initial begin
        repeat (12) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (2) @(negedge ref_clk);
        t_transfer();
        t_copy();
        t_arith();
        t_stop();
        close_out();
    end
endmodule // tb_top
`default_nettype wire
